// *** verilog/pio_top.sv ***
// Programmable port block: 87 two-way pins, one input shared with the non-maskable interrupt.
// Assumes pins are sampled on sys_clk; the pad ring turns out/enable/pull into wire levels.
// Contract
// - Provide 87 two-way port bits and one input-only bit, pins shared with peripherals.
// - Each port has direction and data latches; each pull-up bit governs four bits.
// - An output bit drives its pin to the written level, push-pull.
// - Port seven bits zero and one only pull low or release, never drive high.
// - Writing data of an input bit updates the latch while the pin floats.
// - In expansion or microprocessor mode, bus pin data and direction ignore writes.
// - Reading data of an output bit returns the latch, not the pin.
// - Reading data of an input bit returns the sampled pin level.
// - Port nine direction writes take effect only while protection is lifted.
// - The input-only bit has no direction or pull-up and shares the interrupt pin.
// - A falling edge on the shared input always raises the non-maskable interrupt.
// - Enabled pull-ups connect only on input bits of the group.
// - Bus-side pull-ups connect only in single-chip mode; their bits stay writable.
// - After reset every two-way bit is an input until software sets it.
// - With the strap at single-chip, bus control pins stay ports until mode changes.
module pio_top
    import pio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic processor_mode_strap,
    input wire logic [NPIN-1:0] pinIn,
    output logic [NPIN-1:0] pinOut_q,
    output logic [NPIN-1:0] pinOe_q,
    output logic [NPIN-1:0] pullUpEn_q,
    output logic nmiRequest_q
);
    pio_reg_if regs ();

    logic [NPORT-1:0][7:0] dataLatch_q;
    logic [NPORT-1:0][7:0] dir_q;
    logic [NPULL_REG-1:0][7:0] pull_q;
    logic [7:0] prot_q;
    pio_mode_e mode_q;
    logic strapTaken_q;
    logic nmiPrev_q;
    logic [NPIN-1:0] pinSync;
    logic [NPIN-1:0] pinOutD;
    logic [NPIN-1:0] pinOeD;
    logic [NPIN-1:0] pullD;
    logic busMode;
    logic [1:0] wrRegion;
    logic [3:0] wrIdx;
    logic [1:0] rdRegion;
    logic [3:0] rdIdx;
    logic wrStrobe;

    // Bits of one port that the external bus owns in the current mode.
    function automatic logic [7:0] lockByte(input int p, input logic bus);
        logic [7:0] m;
        m = BUS_LOCK_MASK[p*8 +: 8];
        return bus ? m : 8'h00;
    endfunction

    // Merge a write into a port byte, keeping the bits that must not change.
    function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] nw,
                                             input logic [7:0] keep);
        return (old & keep) | (nw & ~keep);
    endfunction

    pio_axi_slave u_slave (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .regs(regs)
    );

    pio_sync #(.W(NPIN)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // Address decode shared by the write and read paths.
    assign busMode = (mode_q != MODE_SINGLE);
    assign wrRegion = regs.wrAddr[7:6];
    assign wrIdx = regs.wrAddr[5:2];
    assign rdRegion = regs.rdAddr[7:6];
    assign rdIdx = regs.rdAddr[5:2];
    assign wrStrobe = regs.wrEn && regs.wrLane;

    // A write hits when its word exists; the misc region holds three words.
    always_comb begin
        case (wrRegion)
            REGION_DATA: regs.wrHit = (wrIdx < 4'(NPORT));
            REGION_DIR: regs.wrHit = (wrIdx < 4'(NPORT));
            REGION_PULL: regs.wrHit = (wrIdx < 4'(NPULL_REG));
            REGION_MISC: regs.wrHit = (regs.wrAddr == OFS_PROTECT) || (regs.wrAddr == OFS_MODE)
                                      || (regs.wrAddr == OFS_STATUS);
            default: regs.wrHit = 1'b0;
        endcase
    end

    // Data latches: input bits still store, bus-owned bits hold their value.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dataLatch_q <= {NPORT{DATA_RESET}};
        end else if (wrStrobe && wrRegion == REGION_DATA) begin
            for (int p = 0; p < NPORT; p++) begin
                if (wrIdx == 4'(p)) begin
                    dataLatch_q[p] <= mergeByte(dataLatch_q[p], regs.wrData,
                                                lockByte(p, busMode));
                end
            end
        end
    end

    // Direction latches come up as inputs; port nine needs the protection bit.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dir_q <= {NPORT{DIR_RESET}};
        end else if (wrStrobe && wrRegion == REGION_DIR) begin
            for (int p = 0; p < NPORT; p++) begin
                if (wrIdx == 4'(p) && (p != PORT_NINE || prot_q[PROT_PORT9_BIT])) begin
                    dir_q[p] <= mergeByte(dir_q[p], regs.wrData, lockByte(p, busMode))
                                & DIR_PRESENT_MASK[p*8 +: 8];
                end
            end
        end
    end

    // Pull-up group enables stay writable in every mode.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pull_q <= {NPULL_REG{PULL_RESET}};
        end else if (wrStrobe && wrRegion == REGION_PULL) begin
            for (int r = 0; r < NPULL_REG; r++) begin
                if (wrIdx == 4'(r)) begin
                    pull_q[r] <= regs.wrData;
                end
            end
        end
    end

    // Protection latch; it stays set until software clears it, so port nine stays open.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prot_q <= PROT_RESET;
        end else if (wrStrobe && regs.wrAddr == OFS_PROTECT) begin
            prot_q <= regs.wrData;
        end
    end

    // The strap is caught on the first edge after reset, so bus pins start as ports.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= MODE_SINGLE;
            strapTaken_q <= 1'b0;
        end else if (!strapTaken_q) begin
            strapTaken_q <= 1'b1;
            mode_q <= processor_mode_strap ? MODE_MICRO : MODE_SINGLE;
        end else if (wrStrobe && regs.wrAddr == OFS_MODE) begin
            mode_q <= pio_mode_e'(regs.wrData[1:0]);
        end
    end

    // Pin drive: push-pull follows the latch, port seven bits zero and one only sink.
    always_comb begin
        pinOutD = dataLatch_q;
        pinOeD = dir_q & DIR_PRESENT_MASK;
        pinOutD[PORT_SEVEN_BIT_ONE:PORT_SEVEN_BIT_ZERO] = 2'b00;
        pinOeD[PORT_SEVEN_BIT_ONE:PORT_SEVEN_BIT_ZERO] =
            dir_q[7][1:0] & ~dataLatch_q[7][1:0];
        for (int i = 0; i < NPIN; i++) begin
            pullD[i] = pull_q[i / 32][(i / 4) % 8] & ~dir_q[i / 8][i % 8]
                       & DIR_PRESENT_MASK[i] & (!busMode || !PULL_SC_ONLY_MASK[i]);
        end
    end

    // Pad controls are registered so the pad ring sees clean levels.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinOut_q <= '0;
            pinOe_q <= '0;
            pullUpEn_q <= '0;
        end else begin
            pinOut_q <= pinOutD;
            pinOe_q <= pinOeD;
            pullUpEn_q <= pullD;
        end
    end

    // The interrupt cannot be masked, so every synchronised falling edge is reported.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            nmiPrev_q <= 1'b0; // Same as the synchroniser's reset, so no false edge.
            nmiRequest_q <= 1'b0;
        end else begin
            nmiPrev_q <= pinSync[NMI_SHARED_INPUT_BIT];
            nmiRequest_q <= nmiPrev_q && !pinSync[NMI_SHARED_INPUT_BIT];
        end
    end

    // Read mux: output bits show the latch, input bits the synchronised pin.
    always_comb begin
        regs.rdData = 8'h00;
        regs.rdHit = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            if (rdIdx == 4'(p)) begin
                case (rdRegion)
                    REGION_DATA: begin
                        regs.rdData = (dir_q[p] & dataLatch_q[p])
                                      | (~dir_q[p] & pinSync[p*8 +: 8]);
                        regs.rdHit = 1'b1;
                    end
                    REGION_DIR: begin
                        regs.rdData = dir_q[p];
                        regs.rdHit = 1'b1;
                    end
                    REGION_PULL: begin
                        regs.rdData = (p < NPULL_REG) ? pull_q[p % NPULL_REG] : 8'h00;
                        regs.rdHit = (p < NPULL_REG);
                    end
                    default: begin
                        regs.rdData = 8'h00;
                    end
                endcase
            end
        end
        if (regs.rdAddr == OFS_PROTECT) begin
            regs.rdData = prot_q;
            regs.rdHit = 1'b1;
        end else if (regs.rdAddr == OFS_MODE) begin
            regs.rdData = {6'h00, mode_q};
            regs.rdHit = 1'b1;
        end else if (regs.rdAddr == OFS_STATUS) begin
            regs.rdData = 8'h00;
            regs.rdData[STAT_NMI_LEVEL_BIT] = pinSync[NMI_SHARED_INPUT_BIT];
            regs.rdData[STAT_STRAP_BIT] = processor_mode_strap;
            regs.rdHit = 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_input_floats: assert property ($past(resetn) |-> (pinOe_q & ~$past(dir_q)) == '0)
        else $error("a pin is driven while its direction is input");
    a_pushpull_level: assert property ($past(resetn) |->
        ((pinOut_q ^ $past(dataLatch_q)) & ~OPEN_DRAIN_MASK) == '0)
        else $error("push-pull pin level differs from its latch");
    a_open_drain_sink: assert property ($past(resetn) |-> pinOut_q[57:56] == 2'b00
        && pinOe_q[57:56] == ($past(dir_q[7][1:0]) & ~$past(dataLatch_q[7][1:0])))
        else $error("open-drain pin drives high or fails to sink");
    a_pull_inputs_only: assert property ($past(resetn) |->
        (pullUpEn_q & $past(dir_q)) == '0)
        else $error("pull-up enabled on an output bit");
    a_pull_bus_mode: assert property ($past(busMode) |->
        (pullUpEn_q & PULL_SC_ONLY_MASK) == '0)
        else $error("bus-side pull-up connected outside single-chip mode");
    a_nmi_falling: assert property ($fell(pinSync[NMI_SHARED_INPUT_BIT])
        |=> nmiRequest_q)
        else $error("falling edge on the shared input raised no interrupt");
    a_bus_pins_locked: assert property (busMode && regs.wrEn |=>
        $stable(dataLatch_q[5:0]) && $stable(dir_q[5:0]))
        else $error("bus-owned port latch changed in bus mode");
    a_port9_protect: assert property (regs.wrEn && wrRegion == REGION_DIR
        && wrIdx == 4'(PORT_NINE) && !prot_q[PROT_PORT9_BIT] |=> $stable(dir_q[PORT_NINE]))
        else $error("port nine direction changed while protected");
    a_dir_only_by_write: assert property (!regs.wrEn |=> $stable(dir_q))
        else $error("direction changed without a write");
    a_nmi_no_drive: assert property (!dir_q[8][5] && !pinOe_q[NMI_SHARED_INPUT_BIT]
        && !pullUpEn_q[NMI_SHARED_INPUT_BIT])
        else $error("shared interrupt input is driven or pulled");
    a_read_output_latch: assert property (rdRegion == REGION_DATA && rdIdx < 4'(NPORT) |->
        ((regs.rdData ^ dataLatch_q[rdIdx]) & dir_q[rdIdx]) == 8'h00)
        else $error("read of an output bit does not return the latch");
    a_read_input_pin: assert property (rdRegion == REGION_DATA && rdIdx < 4'(NPORT) |->
        ((regs.rdData ^ pinSync[rdIdx*8 +: 8]) & ~dir_q[rdIdx]) == 8'h00)
        else $error("read of an input bit does not return the pin");
    a_strap_start: assert property ($rose(strapTaken_q) |->
        mode_q == ($past(processor_mode_strap) ? MODE_MICRO : MODE_SINGLE))
        else $error("start mode does not follow the strap");

    c_open_drain_sink: cover property (pinOe_q[PORT_SEVEN_BIT_ZERO] && !pinOut_q[56]);
    c_nmi_event: cover property (nmiRequest_q);
    c_port9_written: cover property (prot_q[PROT_PORT9_BIT] && regs.wrEn
        && wrRegion == REGION_DIR && wrIdx == 4'(PORT_NINE));
    c_bus_mode_pull: cover property (busMode && pull_q[0] != 8'h00);
endmodule // pio_top

// *** verilog/pio_pkg.sv ***
// Package for the programmable port block: register map, field positions, pin masks, modes.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address and eleven 8-bit ports.
package pio_pkg;
    localparam int NPORT = 11;
    localparam int NPIN = 88;
    localparam int ADDR_W = 8;
    localparam int PORT_NINE = 9;
    localparam int NMI_SHARED_INPUT_BIT = 69;
    localparam int PORT_SEVEN_BIT_ZERO = 56;
    localparam int PORT_SEVEN_BIT_ONE = 57;
    localparam int NPULL_REG = 3;

    // Address regions are picked by byte address bits 7:6; the word index is bits 5:2.
    localparam logic [1:0] REGION_DATA = 2'h0;
    localparam logic [1:0] REGION_DIR = 2'h1;
    localparam logic [1:0] REGION_PULL = 2'h2;
    localparam logic [1:0] REGION_MISC = 2'h3;
    localparam logic [7:0] OFS_DATA_BASE = 8'h00;
    localparam logic [7:0] OFS_DIR_BASE = 8'h40;
    localparam logic [7:0] OFS_PULL_BASE = 8'h80;
    localparam logic [7:0] OFS_PROTECT = 8'hC0;
    localparam logic [7:0] OFS_MODE = 8'hC4;
    localparam logic [7:0] OFS_STATUS = 8'hC8;

    localparam int PROT_PORT9_BIT = 2;
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PULL_RESET = 8'h00;
    localparam int STAT_NMI_LEVEL_BIT = 0;
    localparam int STAT_STRAP_BIT = 1;

    // Pins that carry the external bus in expansion and microprocessor modes (ports 0 to 5).
    localparam logic [NPIN-1:0] BUS_LOCK_MASK = 88'h0000_0000_FFFF_FFFF_FFFF;
    // Pull-ups of ports 0 to 3, bits 0 to 3 of port 4 and port 5 work in single-chip only.
    localparam logic [NPIN-1:0] PULL_SC_ONLY_MASK = 88'h0000_0000_FF0F_FFFF_FFFF;
    // Bits that have a direction latch at all: every pin but the shared interrupt input.
    localparam logic [NPIN-1:0] DIR_PRESENT_MASK = ~(88'h1 << NMI_SHARED_INPUT_BIT);
    localparam logic [NPIN-1:0] OPEN_DRAIN_MASK = 88'h3 << PORT_SEVEN_BIT_ZERO;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_EXPAND = 2'b01,
        MODE_RSVD = 2'b10,
        MODE_MICRO = 2'b11
    } pio_mode_e;
endpackage

// *** verilog/pio_reg_if.sv ***
// Interface between the AXI4-Lite slave and the port register file.
// Assumes writes are single-cycle strobes and reads are combinational lookups.
interface pio_reg_if;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic wrLane;
    logic wrHit;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic rdHit;

    modport bus (
        output wrEn, wrAddr, wrData, wrLane, rdAddr,
        input wrHit, rdData, rdHit
    );
    modport regs (
        input wrEn, wrAddr, wrData, wrLane, rdAddr,
        output wrHit, rdData, rdHit
    );
endinterface

// *** verilog/pio_sync.sv ***
// Two-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is a separate level; no bit-to-bit coherence is promised.
module pio_sync #(
    parameter int W = 88
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage, to let metastability settle.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

    a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(resetn, 2) |-> syncOut == $past(asyncIn, 2))
        else $error("pin synchroniser output is not the input two cycles late");
endmodule // pio_sync

// *** verilog/pio_axi_slave.sv ***
// AXI4-Lite slave that turns bus transfers into register strobes and lookups.
// Assumes one write and one read outstanding at most; all AXI outputs are registered.
module pio_axi_slave
    import pio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    pio_reg_if.bus regs
);
    logic awHeld_q;
    logic wHeld_q;
    logic rdPend_q;
    logic [7:0] awAddr_q;
    logic [7:0] wData_q;
    logic wLane_q;
    logic [7:0] arAddr_q;

    // A write fires once address and data are both held and the last response is gone.
    assign regs.wrEn = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign regs.wrAddr = awAddr_q;
    assign regs.wrData = wData_q;
    assign regs.wrLane = wLane_q;
    assign regs.rdAddr = arAddr_q;

    // Write address and data channels are taken independently, in either order.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 8'h00;
            wLane_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (regs.wrEn) begin
                awHeld_q <= 1'b0;
            end else if (!awHeld_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata[7:0]; // Registers are eight bits in the low lane.
                wLane_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (regs.wrEn) begin
                wHeld_q <= 1'b0;
            end else if (!wHeld_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response; an unmapped address answers SLVERR and stores nothing.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (regs.wrEn) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= regs.wrHit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read path; the pin view is sampled one cycle after the address is taken.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            rdPend_q <= 1'b0;
            arAddr_q <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                arAddr_q <= s_axi_araddr;
                rdPend_q <= 1'b1;
            end else if (rdPend_q) begin
                rdPend_q <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, regs.rdData};
                s_axi_rresp <= regs.rdHit ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // pio_axi_slave

// *** testbench/pio_pins_model.sv ***
// Board model for the port pads: block drive first, then board drive, then pull-up.
// Assumes the bench drives every pad that it reads back.
module pio_pins_model
    import pio_pkg::*;
(
    input wire logic [NPIN-1:0] pinOut_q,
    input wire logic [NPIN-1:0] pinOe_q,
    input wire logic [NPIN-1:0] pullUpEn_q,
    input wire logic [NPIN-1:0] extDrv,
    input wire logic [NPIN-1:0] extEn,
    output logic [NPIN-1:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pad with no driver and no pull reads low here; the bench enables board drive on every pad, read or not.
    assign pinIn = (pinOe_q & pinOut_q) | (~pinOe_q & extEn & extDrv)
        | (~pinOe_q & ~extEn & pullUpEn_q);
endmodule // pio_pins_model

// *** testbench/programmable_io_ports_test.sv ***
// Bench for the port block: AXI4-Lite tasks and directed checks.
// Assumes the pad model closes the loop from pin outputs to pin inputs.
module programmable_io_ports_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
    logic sys_clk, resetn = 0, processor_mode_strap = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rdat;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, nmiRequest_q;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, nmiCnt;
    logic [1:0] s_axi_bresp, s_axi_rresp, bres, rres;
    logic [NPIN-1:0] pinIn, pinOut_q, pinOe_q, pullUpEn_q, extDrv = '0, extEn = '1;
    int failures = 0, tests_run = 0, cyc = 0;
    pio_top i_dut (.*);
    pio_pins_model i_pins (.*);
    // Free-running clock.
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic finish_test;
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Each channel is released at its own handshake edge; pads settle before return.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw, w;
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge sys_clk);
            if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
            if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
        end while (aw || w);
        do @(posedge sys_clk); while (!s_axi_bvalid);
        bres = s_axi_bresp;
        s_axi_bready <= 0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rdat = s_axi_rdata[7:0];
        rres = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge sys_clk);
    endtask
    // Hang guard: well above the few hundred cycles the sequence needs.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin failures++; finish_test; end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1;
        @(posedge sys_clk);
        rd(8'h58); `CHK(rdat, 8'h00)
        extDrv[55:48] <= 8'h3C;
        wr(8'h18, 8'hA5); `CHK(pinOe_q[55:48], 8'h00)
        rd(8'h18); `CHK(rdat, 8'h3C)
        wr(8'h58, 8'hFF); `CHK(pinOut_q[55:48], 8'hA5)
        `CHK(bres, AXI_OKAY)
        rd(8'h18); `CHK(rdat, 8'hA5)
        wr(8'h84, 8'h30); `CHK(pullUpEn_q[55:48], 8'h00)
        wr(8'h58, 8'h0F); `CHK(pullUpEn_q[55:48], 8'hF0)
        wr(8'h58, 8'h0F); rd(8'h58); `CHK(rdat, 8'h0F)
        wr(8'h60, 8'hFF); `CHK(pinOe_q[69], 1'b0)
        $display("test direction done");
        wr(8'h1C, 8'hFC);
        wr(8'h5C, 8'hFF); `CHK({pinOe_q[57:56], pinOut_q[57:56]}, 4'hC)
        wr(8'h1C, 8'hFF); `CHK({pinOe_q[57:56], pinOut_q[57:56]}, 4'h0)
        rd(8'h1C); `CHK(rdat, 8'hFF)
        wr(8'h64, 8'hFF); rd(8'h64); `CHK(rdat, 8'h00)
        wr(8'hC0, 8'h04); wr(8'h64, 8'hFF); rd(8'h64); `CHK(rdat, 8'hFF)
        s_axi_wstrb <= 4'hE;
        wr(8'hC0, 8'h00); rd(8'hC0); `CHK(rdat, 8'h04)
        s_axi_wstrb <= 4'hF;
        $display("test protect done");
        wr(8'hC4, 8'h01); wr(8'h40, 8'hFF); rd(8'h40); `CHK(rdat, 8'h00)
        wr(8'h80, 8'h01); `CHK(pullUpEn_q[3:0], 4'h0)
        rd(8'h80); `CHK(rdat, 8'h01)
        wr(8'hC4, 8'h00); `CHK(pullUpEn_q[3:0], 4'hF)
        wr(8'hD0, 8'h01); `CHK(bres, AXI_SLVERR)
        rd(8'hD0); `CHK({rres, rdat}, {AXI_SLVERR, 8'h00})
        $display("test mode done");
        extDrv[69] <= 1;
        repeat (4) @(posedge sys_clk);
        extDrv[69] <= 0;
        nmiCnt = 0;
        repeat (8) @(posedge sys_clk) nmiCnt += {3'h0, nmiRequest_q};
        `CHK(nmiCnt, 4'h1)
        $display("test interrupt done");
        processor_mode_strap <= 1;
        resetn <= 0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1;
        nmiCnt = 0;
        repeat (3) @(posedge sys_clk) nmiCnt += {3'h0, nmiRequest_q};
        `CHK(nmiCnt, 4'h0)
        rd(8'hC4); `CHK(rdat, 8'h03)
        rd(8'h58); `CHK(rdat, 8'h00)
        $display("test restart done");
        finish_test;
    end
endmodule // programmable_io_ports_test
